// ---- verilog/dmacs_top.sv ----
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module dmacs_fifo #(
    parameter int W = 32,
    parameter int D = 4
) (
    input  wire logic         ref_clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] in_data_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    output logic              room_nxt_o,
    output logic [W-1:0]      out_data_o,
    output logic              out_valid_o,
    input  wire logic         out_ready_i
);
    localparam int AW = $clog2(D);
    localparam int CW = $clog2(D + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(D);
    localparam logic [AW-1:0] LAST_PTR = AW'(D - 1);

    logic [W-1:0]  mem_r   [D];
    logic [W-1:0]  mem_nxt [D];
    logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic          rdy_r, rdy_nxt, val_r, val_nxt;
    logic          push, pop;

    always_comb begin
        push    = in_valid_i & rdy_r;
        pop     = val_r & out_ready_i;
        mem_nxt = mem_r;
        wr_nxt  = wr_r;
        rd_nxt  = rd_r;
        cnt_nxt = cnt_r;
        if (push) begin
            mem_nxt[wr_r] = in_data_i;
            wr_nxt = (wr_r == LAST_PTR) ? '0 : wr_r + 1'b1;
        end
        if (pop) begin
            rd_nxt = (rd_r == LAST_PTR) ? '0 : rd_r + 1'b1;
        end
        if (push && !pop) begin
            cnt_nxt = cnt_r + 1'b1;
        end else if (pop && !push) begin
            cnt_nxt = cnt_r - 1'b1;
        end
        rdy_nxt = (cnt_nxt != FULL_CNT);
        val_nxt = (cnt_nxt != '0);
    end

    always_ff @(posedge ref_clk_i) begin
        mem_r <= mem_nxt;
        if (rst_i) begin
            wr_r  <= '0;
            rd_r  <= '0;
            cnt_r <= '0;
            rdy_r <= 1'b0;
            val_r <= 1'b0;
        end else begin
            wr_r  <= wr_nxt;
            rd_r  <= rd_nxt;
            cnt_r <= cnt_nxt;
            rdy_r <= rdy_nxt;
            val_r <= val_nxt;
        end
    end

    assign in_ready_o  = rdy_r;
    assign room_nxt_o  = rdy_nxt;
    assign out_data_o  = mem_r[rd_r];
    assign out_valid_o = val_r;
endmodule : dmacs_fifo

////////////////////////////////////////////////////////////////////////////////
// What this block does
// - A channel's enable clears by itself when its transfer finishes.
// - Software can read each channel's enable state as a plain flag.
// - Mode of a chosen primary or alternate structure is readable, stop after completion.
// - Mode is stop, basic, auto, double buffer, memory or peripheral task list.
// - A software request starts a channel as if its peripheral had asked.
// - Completion on the software channel pulses the dedicated completion line.
// - Completion on other channels pulses that channel's peripheral completion line.
// - Task list setup selects peripheral paced or memory operation by a flag.
// - Per-channel selector; with secondary chosen, default requests are ignored.
// - Masks force many channels to default or secondary in one operation.
// - Transfer size counts items of 8, 16 or 32 bits.
// - Reading size after a partial transfer gives the items still remaining.
// - After full completion the remaining item count reads zero.
// - The engine writes stop into a structure's mode when it finishes.
// - Double buffer mode switches between primary and alternate structures.
module dmacs_top
    import dmacs_pkg::*;
(
    input  wire logic                         ref_clk_i,
    input  wire logic                         rst_i,
    input  wire logic                         cfg_we_i,
    input  wire logic [dmacs_pkg::CH_W-1:0]   cfg_ch_i,
    input  wire logic                         cfg_struct_i,
    input  wire dmacs_pkg::dmacs_mode_t       cfg_mode_i,
    input  wire dmacs_pkg::dmacs_item_t       cfg_item_i,
    input  wire logic [dmacs_pkg::SIZE_W-1:0] cfg_count_i,
    input  wire logic                         sg_we_i,
    input  wire logic [dmacs_pkg::CH_W-1:0]   sg_ch_i,
    input  wire logic [dmacs_pkg::SIZE_W-1:0] sg_task_count_i,
    input  wire logic                         sg_periph_i,
    input  wire logic [dmacs_pkg::NUM_CH-1:0] enable_set_i,
    input  wire logic [dmacs_pkg::NUM_CH-1:0] disable_i,
    input  wire logic [dmacs_pkg::NUM_CH-1:0] sw_req_i,
    input  wire logic [dmacs_pkg::NUM_CH-1:0] default_req_i,
    input  wire logic [dmacs_pkg::NUM_CH-1:0] second_req_i,
    input  wire logic [dmacs_pkg::NUM_CH-1:0] select_default_i,
    input  wire logic [dmacs_pkg::NUM_CH-1:0] select_secondary_i,
    input  wire logic [dmacs_pkg::CH_W-1:0]   qry_ch_i,
    input  wire logic                         qry_struct_i,
    output logic                              qry_enabled_o,
    output dmacs_pkg::dmacs_mode_t            qry_mode_o,
    output logic [dmacs_pkg::SIZE_W-1:0]      qry_remaining_o,
    output logic [dmacs_pkg::NUM_CH-1:0]      enabled_o,
    output logic [dmacs_pkg::NUM_CH-1:0]      secondary_sel_o,
    input  wire logic [dmacs_pkg::DATA_W-1:0] src_data_i,
    input  wire logic                         src_valid_i,
    output logic                              src_ready_o,
    output logic [dmacs_pkg::DATA_W-1:0]      dst_data_o,
    output logic                              dst_valid_o,
    input  wire logic                         dst_ready_i,
    output logic                              sw_done_o,
    output logic [dmacs_pkg::NUM_CH-1:0]      periph_done_o
);
    import dmacs_pkg::*;

    dmacs_mode_t           mode_r   [NUM_CH][2];
    dmacs_mode_t           mode_nxt [NUM_CH][2];
    logic [SIZE_W-1:0]     size_r   [NUM_CH][2];
    logic [SIZE_W-1:0]     size_nxt [NUM_CH][2];
    dmacs_item_t           item_r   [NUM_CH][2];
    dmacs_item_t           item_nxt [NUM_CH][2];
    logic [NUM_CH-1:0]     en_r, en_nxt, alt_r, alt_nxt, pend_r, pend_nxt;
    logic [NUM_CH-1:0]     sec_r, sec_nxt, req_vec, pdone_r, pdone_nxt;
    dmacs_state_t          state_r, state_nxt;
    logic [CH_W-1:0]       ch_r, ch_nxt;
    logic                  srdy_r, srdy_nxt, swd_r, swd_nxt;
    logic                  qen_r, qen_nxt;
    dmacs_mode_t           qmode_r, qmode_nxt;
    logic [SIZE_W-1:0]     qsize_r, qsize_nxt;
    logic                  push, room_nxt, fifo_rdy, run_nxt, s, found;
    dmacs_mode_t           m;
    logic [DATA_W-1:0]     push_data;

    ////////////////////////////////////////////////////////////////////////////
    // Request selection and the transfer engine.
    always_comb begin
        mode_nxt  = mode_r;
        size_nxt  = size_r;
        item_nxt  = item_r;
        en_nxt    = en_r;
        alt_nxt   = alt_r;
        pend_nxt  = pend_r;
        sec_nxt   = sec_r;
        state_nxt = state_r;
        ch_nxt    = ch_r;
        pdone_nxt = '0;
        swd_nxt   = 1'b0;
        found     = 1'b0;
        run_nxt   = 1'b0;
        push      = src_valid_i & srdy_r & fifo_rdy;
        s         = alt_r[ch_r];
        m         = mode_r[ch_r][s];
        push_data = src_data_i;
        for (int c = 0; c < NUM_CH; c++) begin
            req_vec[c] = en_r[c] & (pend_r[c] | (sec_r[c] ? second_req_i[c]
                                                           : default_req_i[c]));
        end
        case (item_r[ch_r][s])
            item_8:  push_data = src_data_i & MASK_8;
            item_16: push_data = src_data_i & MASK_16;
            default: push_data = src_data_i & MASK_32;
        endcase
        case (state_r)
            st_idle: begin
                for (int c = 0; c < NUM_CH; c++) begin
                    if (req_vec[c] && !found) begin
                        found       = 1'b1;
                        ch_nxt      = CH_W'(c);
                        pend_nxt[c] = 1'b0;
                        if (mode_r[c][alt_r[c]] == mode_stop) begin
                            en_nxt[c] = 1'b0;
                        end else begin
                            state_nxt = st_move;
                        end
                    end
                end
            end
            default: begin
                if (push) begin
                    size_nxt[ch_r][s] = size_r[ch_r][s] - 1'b1;
                end
                if (!en_r[ch_r]) begin
                    state_nxt = st_idle;
                end else if (size_nxt[ch_r][s] == '0) begin
                    mode_nxt[ch_r][s] = mode_stop;
                    if (ch_r == CH_W'(SW_CH)) begin
                        swd_nxt = 1'b1;
                    end else begin
                        pdone_nxt[ch_r] = 1'b1;
                    end
                    if (m == mode_double_buffer && mode_r[ch_r][!s] != mode_stop) begin
                        alt_nxt[ch_r] = !s;
                    end else begin
                        en_nxt[ch_r] = 1'b0;
                        state_nxt    = st_idle;
                    end
                end else if ((m == mode_basic || m == mode_peripheral_task_list)
                             && !req_vec[ch_r]) begin
                    state_nxt = st_idle;
                end
            end
        endcase
        if (state_nxt == st_move && state_r == st_move) begin
            run_nxt = (size_nxt[ch_r][alt_nxt[ch_r]] != '0);
        end
        srdy_nxt = run_nxt & room_nxt;
        if (cfg_we_i) begin
            mode_nxt[cfg_ch_i][cfg_struct_i] = cfg_mode_i;
            size_nxt[cfg_ch_i][cfg_struct_i] = cfg_count_i;
            item_nxt[cfg_ch_i][cfg_struct_i] = cfg_item_i;
        end
        if (sg_we_i) begin
            mode_nxt[sg_ch_i][primary_structure_select] = sg_periph_i
                ? mode_peripheral_task_list : mode_memory_task_list;
            size_nxt[sg_ch_i][primary_structure_select] = sg_task_count_i;
            alt_nxt[sg_ch_i] = primary_structure_select;
        end
        en_nxt   = (en_nxt & ~disable_i) | enable_set_i;
        pend_nxt = pend_nxt | sw_req_i;
        sec_nxt  = (sec_nxt & ~select_default_i) | select_secondary_i;
        qen_nxt   = en_r[qry_ch_i];
        qmode_nxt = mode_r[qry_ch_i][qry_struct_i];
        qsize_nxt = size_r[qry_ch_i][qry_struct_i];
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            for (int c = 0; c < NUM_CH; c++) begin
                for (int k = 0; k < 2; k++) begin
                    mode_r[c][k] <= MODE_RST;
                    size_r[c][k] <= SIZE_RST;
                    item_r[c][k] <= ITEM_RST;
                end
            end
            en_r    <= MASK_RST;
            alt_r   <= MASK_RST;
            pend_r  <= MASK_RST;
            sec_r   <= MASK_RST;
            pdone_r <= MASK_RST;
            state_r <= st_idle;
            ch_r    <= '0;
            srdy_r  <= 1'b0;
            swd_r   <= 1'b0;
            qen_r   <= 1'b0;
            qmode_r <= MODE_RST;
            qsize_r <= SIZE_RST;
        end else begin
            mode_r  <= mode_nxt;
            size_r  <= size_nxt;
            item_r  <= item_nxt;
            en_r    <= en_nxt;
            alt_r   <= alt_nxt;
            pend_r  <= pend_nxt;
            sec_r   <= sec_nxt;
            pdone_r <= pdone_nxt;
            state_r <= state_nxt;
            ch_r    <= ch_nxt;
            srdy_r  <= srdy_nxt;
            swd_r   <= swd_nxt;
            qen_r   <= qen_nxt;
            qmode_r <= qmode_nxt;
            qsize_r <= qsize_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Data buffer between source and destination.
    dmacs_fifo #(
        .W (DATA_W),
        .D (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk_i   (ref_clk_i),
        .rst_i       (rst_i),
        .in_data_i   (push_data),
        .in_valid_i  (push),
        .in_ready_o  (fifo_rdy),
        .room_nxt_o  (room_nxt),
        .out_data_o  (dst_data_o),
        .out_valid_o (dst_valid_o),
        .out_ready_i (dst_ready_i)
    );

    assign qry_enabled_o   = qen_r;
    assign qry_mode_o      = qmode_r;
    assign qry_remaining_o = qsize_r;
    assign enabled_o       = en_r;
    assign secondary_sel_o = sec_r;
    assign src_ready_o     = srdy_r;
    assign sw_done_o       = swd_r;
    assign periph_done_o   = pdone_r;
endmodule : dmacs_top

// ---- verilog/dmacs_pkg.sv ----
package dmacs_pkg;
    localparam int NUM_CH     = 4;
    localparam int CH_W       = 2;
    localparam int SIZE_W     = 10;
    localparam int DATA_W     = 32;
    localparam int FIFO_DEPTH = 4;
    localparam int SW_CH      = 3;

    typedef enum logic [2:0] {
        mode_stop,
        mode_basic,
        mode_auto,
        mode_double_buffer,
        mode_memory_task_list,
        mode_peripheral_task_list
    } dmacs_mode_t;

    typedef enum logic [1:0] {
        item_8,
        item_16,
        item_32
    } dmacs_item_t;

    typedef enum logic {
        st_idle,
        st_move
    } dmacs_state_t;

    localparam logic primary_structure_select   = 1'b0;
    localparam logic alternate_structure_select = 1'b1;

    localparam logic [SIZE_W-1:0] SIZE_RST = 10'h000;
    localparam dmacs_mode_t       MODE_RST = mode_stop;
    localparam dmacs_item_t       ITEM_RST = item_32;
    localparam logic [NUM_CH-1:0] MASK_RST = 4'h0;
    localparam logic [DATA_W-1:0] MASK_8   = 32'h0000_00FF;
    localparam logic [DATA_W-1:0] MASK_16  = 32'h0000_FFFF;
    localparam logic [DATA_W-1:0] MASK_32  = 32'hFFFF_FFFF;
endpackage : dmacs_pkg

// ---- testbench/dmacs_monitor.sv ----
`timescale 1ns/1ps
module dmacs_monitor
    import dmacs_pkg::*;
(
    input wire logic                         ref_clk_i,
    input wire logic                         rst_i,
    input wire logic [dmacs_pkg::NUM_CH-1:0] enable_set_i,
    input wire logic [dmacs_pkg::NUM_CH-1:0] select_default_i,
    input wire logic [dmacs_pkg::NUM_CH-1:0] select_secondary_i,
    input wire logic [dmacs_pkg::NUM_CH-1:0] enabled_o,
    input wire logic [dmacs_pkg::NUM_CH-1:0] secondary_sel_o,
    input wire logic                         src_valid_i,
    input wire logic                         src_ready_o,
    input wire logic [dmacs_pkg::DATA_W-1:0] dst_data_o,
    input wire logic                         dst_valid_o,
    input wire logic                         dst_ready_i,
    input wire logic                         sw_done_o,
    input wire logic [dmacs_pkg::NUM_CH-1:0] periph_done_o
);
    logic [NUM_CH-1:0] sec_r;
    logic [NUM_CH-1:0] def_r;
    always_ff @(posedge ref_clk_i) begin
        sec_r <= select_secondary_i;
        def_r <= select_default_i & ~select_secondary_i;
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    sequence s_beat; src_valid_i && src_ready_o; endsequence
    sequence s_held; dst_valid_o && !dst_ready_i; endsequence
    property p_sec_set; (secondary_sel_o & sec_r) == sec_r; endproperty
    property p_def_set; (secondary_sel_o & def_r) == 4'h0; endproperty
    property p_sel_hold;
        !(|select_default_i) && !(|select_secondary_i) |=> $stable(secondary_sel_o);
    endproperty
    property p_en_rise;
        (enabled_o & ~$past(enabled_o) & ~$past(enable_set_i)) == 4'h0;
    endproperty
    property p_sw_pulse; sw_done_o |=> !sw_done_o; endproperty
    property p_no_bit3; periph_done_o[SW_CH] == 1'b0; endproperty
    property p_beat_push; s_beat |=> dst_valid_o; endproperty
    property p_fifo_hold; s_held |=> dst_valid_o && $stable(dst_data_o); endproperty
    a_sec_set: assert property (p_sec_set) else $error("secondary select lost");
    a_def_set: assert property (p_def_set) else $error("default select lost");
    a_sel_hold: assert property (p_sel_hold) else $error("selector moved");
    a_en_rise: assert property (p_en_rise) else $error("enable rose alone");
    a_sw_pulse: assert property (p_sw_pulse) else $error("sw done too long");
    a_no_bit3: assert property (p_no_bit3) else $error("sw channel on periph");
    a_beat_push: assert property (p_beat_push) else $error("beat not queued");
    a_fifo_hold: assert property (p_fifo_hold) else $error("head changed");
endmodule : dmacs_monitor
bind dmacs_top dmacs_monitor u_mon (.ref_clk_i, .rst_i, .enable_set_i, .select_default_i,
    .select_secondary_i, .enabled_o, .secondary_sel_o, .src_valid_i, .src_ready_o,
    .dst_data_o, .dst_valid_o, .dst_ready_i, .sw_done_o, .periph_done_o);

// ---- testbench/dmacs_far_model.sv ----
`timescale 1ns/1ps
module dmacs_far_model
    import dmacs_pkg::*;
(
    input  wire logic                         ref_clk_i,
    input  wire logic                         rst_i,
    input  wire logic                         stall_i,
    input  wire logic                         slow_i,
    output logic [dmacs_pkg::DATA_W-1:0]      src_data_o,
    output logic                              src_valid_o,
    input  wire logic                         src_ready_i,
    input  wire logic [dmacs_pkg::DATA_W-1:0] dst_data_i,
    input  wire logic                         dst_valid_i,
    output logic                              dst_ready_o,
    output logic [7:0]                        pops_o,
    output logic [dmacs_pkg::DATA_W-1:0]      last_o
);
    logic [DATA_W-1:0] word_r;
    // A word stays offered until taken; an idle source shows the inverse.
    assign src_data_o  = src_valid_o ? word_r : ~word_r;
    assign dst_ready_o = !stall_i;
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            word_r      <= 32'hC3C3_C3C0;
            src_valid_o <= 1'b1;
            pops_o      <= 8'h00;
            last_o      <= 32'h0000_0000;
        end else begin
            if (src_valid_o && src_ready_i) begin
                word_r      <= word_r + 32'h0000_0001;
                src_valid_o <= !slow_i;
            end else begin
                src_valid_o <= 1'b1;
            end
            if (dst_valid_i && dst_ready_o) begin
                pops_o <= pops_o + 8'h01;
                last_o <= dst_data_i;
            end
        end
    end
endmodule : dmacs_far_model

// ---- testbench/dmacs_top_tb.sv ----
`timescale 1ns/1ps
module dmacs_top_tb;
    import dmacs_pkg::*;
    logic ref_clk_i, rst_i, cfg_we_i, cfg_struct_i, sg_we_i, sg_periph_i, qry_struct_i;
    logic [CH_W-1:0] cfg_ch_i, sg_ch_i, qry_ch_i;
    logic [SIZE_W-1:0] cfg_count_i, sg_task_count_i, qry_remaining_o;
    logic [NUM_CH-1:0] enable_set_i, disable_i, sw_req_i, default_req_i, second_req_i;
    logic [NUM_CH-1:0] select_default_i, select_secondary_i, enabled_o, secondary_sel_o;
    logic [NUM_CH-1:0] periph_done_o, done_v;
    logic [DATA_W-1:0] src_data_i, dst_data_o, far_last;
    logic src_valid_i, src_ready_o, dst_valid_o, dst_ready_i, sw_done_o, qry_enabled_o;
    logic stall, slow;
    logic [7:0] far_pops;
    dmacs_mode_t cfg_mode_i, qry_mode_o;
    dmacs_item_t cfg_item_i;
    int errors, cmp_count, cyc;
    assign done_v = {sw_done_o, periph_done_o[2:0]};
    dmacs_top DUT (.ref_clk_i, .rst_i, .cfg_we_i, .cfg_ch_i, .cfg_struct_i, .cfg_mode_i,
        .cfg_item_i, .cfg_count_i, .sg_we_i, .sg_ch_i, .sg_task_count_i, .sg_periph_i,
        .enable_set_i, .disable_i, .sw_req_i, .default_req_i, .second_req_i,
        .select_default_i, .select_secondary_i, .qry_ch_i, .qry_struct_i, .qry_enabled_o,
        .qry_mode_o, .qry_remaining_o, .enabled_o, .secondary_sel_o, .src_data_i,
        .src_valid_i, .src_ready_o, .dst_data_o, .dst_valid_o, .dst_ready_i, .sw_done_o,
        .periph_done_o);
    dmacs_far_model FAR (.ref_clk_i, .rst_i, .stall_i(stall), .slow_i(slow),
        .src_data_o(src_data_i), .src_valid_o(src_valid_i), .src_ready_i(src_ready_o),
        .dst_data_i(dst_data_o), .dst_valid_i(dst_valid_o), .dst_ready_o(dst_ready_i),
        .pops_o(far_pops), .last_o(far_last));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            errors++;
            $display("wrong value %s expected %0h seen %0h", n, e, s);
        end
    endtask : chk
    task automatic wcfg(input int c, s, input dmacs_mode_t m, input dmacs_item_t t, input int n);
        @(posedge ref_clk_i);
        {cfg_we_i, cfg_ch_i, cfg_struct_i, cfg_count_i} <= {1'b1, c[1:0], s[0], n[9:0]};
        cfg_mode_i <= m;
        cfg_item_i <= t;
        @(posedge ref_clk_i);
        cfg_we_i <= 1'b0;
    endtask : wcfg
    task automatic sg(input logic p, input int n);
        @(posedge ref_clk_i);
        {sg_we_i, sg_ch_i, sg_periph_i, sg_task_count_i} <= {1'b1, 2'h1, p, n[9:0]};
        @(posedge ref_clk_i);
        sg_we_i <= 1'b0;
    endtask : sg
    task automatic pulse(input logic [3:0] en, sw, sd, ss, ds);
        @(posedge ref_clk_i);
        {enable_set_i, sw_req_i, select_default_i, select_secondary_i, disable_i} <=
            {en, sw, sd, ss, ds};
        @(posedge ref_clk_i);
        {enable_set_i, sw_req_i, select_default_i, select_secondary_i, disable_i} <= '0;
    endtask : pulse
    task automatic q(input int c, s, input logic en, input dmacs_mode_t m, input int n);
        @(posedge ref_clk_i);
        {qry_ch_i, qry_struct_i} <= {c[1:0], s[0]};
        repeat (2) @(posedge ref_clk_i);
        #1;
        chk("enabled", qry_enabled_o, en);
        chk("mode", qry_mode_o, m);
        chk("remaining", qry_remaining_o, n[9:0]);
    endtask : q
    task automatic wdone(input int b);
        int k;
        k = 0;
        do begin
            @(posedge ref_clk_i);
            #1;
            k++;
        end while (done_v[b] !== 1'b1 && k < 200);
        chk("done", done_v[b], 1'b1);
    endtask : wdone
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk_i = 1'b0;
        forever #20 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 4000) begin
            errors++;
            end_sim();
        end
    end
    initial begin
        rst_i = 1'b1;
        {cfg_we_i, cfg_ch_i, cfg_struct_i, cfg_count_i, sg_we_i, sg_ch_i, sg_task_count_i,
         sg_periph_i, enable_set_i, disable_i, sw_req_i, default_req_i, second_req_i,
         select_default_i, select_secondary_i, qry_ch_i, qry_struct_i, stall, slow} = '0;
        cfg_mode_i = mode_stop;
        cfg_item_i = item_32;
        repeat (20) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        q(0, 0, 1'b0, mode_stop, 0);
        chk("selector", secondary_sel_o, 4'h0);
        $display("test reset finished");
        for (int i = 0; i < 6; i++) begin
            wcfg(1, 1, dmacs_mode_t'(i), item_16, i + 1);
            q(1, 1, 1'b0, dmacs_mode_t'(i), i + 1);
        end
        $display("test modes finished");
        wcfg(0, 0, mode_auto, item_8, 3);
        pulse(4'h1, 4'h1, 4'h0, 4'h0, 4'h0);
        wdone(0);
        q(0, 0, 1'b0, mode_stop, 0);
        chk("byte lane", far_last & 32'hFFFF_FF00, 32'h0);
        $display("test software start finished");
        {stall, slow} <= 2'b11;
        wcfg(1, 0, mode_auto, item_32, 6);
        pulse(4'h2, 4'h2, 4'h0, 4'h0, 4'h0);
        repeat (20) @(posedge ref_clk_i);
        q(1, 0, 1'b1, mode_auto, 2);
        chk("refused", src_ready_o, 1'b0);
        chk("enabled vector", enabled_o, 4'h2);
        stall <= 1'b0;
        wdone(1);
        chk("word", far_last[31:8], 24'hC3C3C3);
        $display("test buffer finished");
        wcfg(3, 0, mode_auto, item_16, 2);
        pulse(4'h8, 4'h8, 4'h0, 4'h0, 4'h0);
        wdone(3);
        chk("half lane", far_last & 32'hFFFF_0000, 32'h0);
        $display("test software channel finished");
        pulse(4'h0, 4'h0, 4'h0, 4'h6, 4'h0);
        #1;
        chk("selector", secondary_sel_o, 4'h6);
        pulse(4'h0, 4'h0, 4'h2, 4'h0, 4'h0);
        #1;
        chk("selector", secondary_sel_o, 4'h4);
        wcfg(2, 0, mode_basic, item_32, 2);
        pulse(4'h4, 4'h0, 4'h0, 4'h0, 4'h0);
        default_req_i <= 4'h4;
        repeat (10) @(posedge ref_clk_i);
        q(2, 0, 1'b1, mode_basic, 2);
        second_req_i <= 4'h4;
        wdone(2);
        {default_req_i, second_req_i} <= '0;
        wcfg(2, 0, mode_basic, item_32, 1);
        pulse(4'h4, 4'h0, 4'h0, 4'h0, 4'h0);
        pulse(4'h0, 4'h0, 4'h0, 4'h0, 4'h4);
        q(2, 0, 1'b0, mode_basic, 1);
        $display("test selector finished");
        wcfg(0, 0, mode_double_buffer, item_32, 1);
        wcfg(0, 1, mode_double_buffer, item_32, 1);
        default_req_i <= 4'h1;
        pulse(4'h1, 4'h0, 4'h0, 4'h0, 4'h0);
        wdone(0);
        wdone(0);
        default_req_i <= 4'h0;
        q(0, 1, 1'b0, mode_stop, 0);
        $display("test double buffer finished");
        sg(1'b1, 3);
        q(1, 0, 1'b0, mode_peripheral_task_list, 3);
        sg(1'b0, 3);
        q(1, 0, 1'b0, mode_memory_task_list, 3);
        pulse(4'h2, 4'h2, 4'h0, 4'h0, 4'h0);
        wdone(1);
        q(1, 0, 1'b0, mode_stop, 0);
        chk("pops", far_pops, 8'h12);
        chk("drained", dst_valid_o, 1'b0);
        $display("test task list finished");
        end_sim();
    end
endmodule : dmacs_top_tb
